// >>> rtl/xsl_status_loopback_regs.sv
// Status, power-on flag and reverse loop-back register bank
`timescale 1ns/10ps
`default_nettype none

`include "xsl_defines.svh"

module xsl_status_loopback_regs #(
  // Arbitrary value; set per silicon revision
  parameter logic [6:0] REVISION = 7'h01
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic regRdValid,
  output logic [3:0] reverseLoopBank0,
  output logic [3:0] reverseLoopBank1,
  output logic [3:0] reverseLoopBank2,
  output logic [3:0] reverseLoopBank3,
  output logic powerOnFlag
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic xsl_pkg::xsl_sel_t decodeAddr(input logic [7:0] addr);
    xsl_pkg::xsl_sel_t sel;
    sel = xsl_pkg::XSL_SEL_NONE;
    unique case (addr)
      `XSL_ADDR_RESERVED: sel = xsl_pkg::XSL_SEL_RESERVED;
      `XSL_ADDR_REV_FLAG: sel = xsl_pkg::XSL_SEL_REV_FLAG;
      `XSL_ADDR_LOOP_LOW: sel = xsl_pkg::XSL_SEL_LOOP_LOW;
      `XSL_ADDR_LOOP_HIGH: sel = xsl_pkg::XSL_SEL_LOOP_HIGH;
      default: sel = xsl_pkg::XSL_SEL_NONE;
    endcase
    return sel;
  endfunction : decodeAddr

  // ---------------------------------------------------------------
  // Field helpers
  // ---------------------------------------------------------------
  // One strobe per target word; reserved and unmapped words hit nothing
  function automatic logic wrHit(
    input logic en,
    input xsl_pkg::xsl_sel_t sel,
    input xsl_pkg::xsl_sel_t target
  );
    return en && (sel == target);
  endfunction : wrHit

  // Lane n of bank b sits at bit n of its word, plus four for odd b (banks 1 and 3)
  function automatic xsl_pkg::xsl_lanes_t bankLanes(
    input xsl_pkg::xsl_byte_t word,
    input logic upperBank
  );
    int base;
    base = upperBank ? `XSL_LANES_PER_BANK : 0;
    return word[base +: `XSL_LANES_PER_BANK];
  endfunction : bankLanes

  // Revision is a constant here, so no write path can ever reach it
  function automatic xsl_pkg::xsl_byte_t statusWord(
    input logic flag
  );
    xsl_pkg::xsl_byte_t word;
    word = `XSL_UNMAPPED_READ;
    word[`XSL_REV_MSB:`XSL_REV_LSB] = REVISION;
    word[`XSL_FLAG_BIT] = flag;
    return word;
  endfunction : statusWord

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  // Assert at once, release after two edges so all flops leave together
  logic rstMeta_q;
  logic rstMeta_d;
  logic rstSyncN_q;
  logic rstSyncN_d;

  always_comb begin
    rstMeta_d = 1'b1;
    rstSyncN_d = rstMeta_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_q <= 1'b0;
      rstSyncN_q <= 1'b0;
    end else begin
      rstMeta_q <= rstMeta_d;
      rstSyncN_q <= rstSyncN_d;
    end
  end

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  xsl_cfg_if cfgLink ();

  xsl_pkg::xsl_sel_t wrSel;
  logic wrFlagReg;

  always_comb begin
    wrSel = decodeAddr(regAddr);
    wrFlagReg = wrHit(regWrEn, wrSel, xsl_pkg::XSL_SEL_REV_FLAG);
    cfgLink.restore = wrFlagReg;
    cfgLink.wrLow = wrHit(regWrEn, wrSel, xsl_pkg::XSL_SEL_LOOP_LOW);
    cfgLink.wrHigh =
      wrHit(regWrEn, wrSel, xsl_pkg::XSL_SEL_LOOP_HIGH);
    // Writes to the reserved word reach no register at all
    cfgLink.wrData = regWrData;
  end

  xsl_loop_bank loopBank (
    .clk(clk),
    .rstSyncN(rstSyncN_q),
    .cfg(cfgLink.bank)
  );

  // ---------------------------------------------------------------
  // Power-on flag
  // ---------------------------------------------------------------
  logic porFlag_q;
  logic porFlag_d;

  // Only reset sets it, so a set never meets a clear in one cycle
  always_comb begin
    porFlag_d = porFlag_q;
    // Data byte is not looked at, only the address
    if (wrFlagReg) begin
      porFlag_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstSyncN_q) begin
    if (!rstSyncN_q) begin
      porFlag_q <= `XSL_FLAG_RESET;
    end else begin
      porFlag_q <= porFlag_d;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  xsl_pkg::xsl_sel_t rdSel;
  xsl_pkg::xsl_byte_t rdWord;
  xsl_pkg::xsl_byte_t rdData_q;
  xsl_pkg::xsl_byte_t rdData_d;
  logic rdValid_q;
  logic rdValid_d;

  always_comb begin
    rdSel = decodeAddr(regAddr);
    rdWord = `XSL_UNMAPPED_READ;
    unique case (rdSel)
      xsl_pkg::XSL_SEL_RESERVED: begin
        rdWord = `XSL_RSVD_READ;
      end
      xsl_pkg::XSL_SEL_REV_FLAG: begin
        rdWord = statusWord(porFlag_q);
      end
      xsl_pkg::XSL_SEL_LOOP_LOW: begin
        rdWord = cfgLink.loopLow;
      end
      xsl_pkg::XSL_SEL_LOOP_HIGH: begin
        rdWord = cfgLink.loopHigh;
      end
      xsl_pkg::XSL_SEL_NONE: begin
        rdWord = `XSL_UNMAPPED_READ;
      end
    endcase
    // A read in the cycle of a write returns the value before it
    // Hold the last answer between reads so the host may sample late
    rdData_d = regRdEn ? rdWord : rdData_q;
    rdValid_d = regRdEn;
  end

  always_ff @(posedge clk or negedge rstSyncN_q) begin
    if (!rstSyncN_q) begin
      rdData_q <= `XSL_RDDATA_RESET;
      rdValid_q <= 1'b0;
    end else begin
      rdData_q <= rdData_d;
      rdValid_q <= rdValid_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign regRdData = rdData_q;
  assign regRdValid = rdValid_q;
  assign powerOnFlag = porFlag_q;

  // ---------------------------------------------------------------
  // Lane enables
  // ---------------------------------------------------------------
  // Straight from the flops: no glitch reaches the analog loop switches
  assign reverseLoopBank0 = bankLanes(cfgLink.loopLow, 1'b0);
  assign reverseLoopBank1 = bankLanes(cfgLink.loopLow, 1'b1);
  assign reverseLoopBank2 = bankLanes(cfgLink.loopHigh, 1'b0);
  assign reverseLoopBank3 = bankLanes(cfgLink.loopHigh, 1'b1);

endmodule : xsl_status_loopback_regs

`default_nettype wire

// >>> rtl/xsl_defines.svh
// Register offsets, field positions and reset values of the status bank
`ifndef XSL_DEFINES_SVH
`define XSL_DEFINES_SVH

`define XSL_ADDR_RESERVED 8'h00
`define XSL_ADDR_REV_FLAG 8'h01
`define XSL_ADDR_LOOP_LOW 8'h02
`define XSL_ADDR_LOOP_HIGH 8'h03

`define XSL_REV_MSB 6
`define XSL_REV_LSB 0
`define XSL_FLAG_BIT 7

`define XSL_FLAG_RESET 1'h1
`define XSL_LOOP_RESET 8'h00
`define XSL_RSVD_READ 8'h00
`define XSL_UNMAPPED_READ 8'h00
`define XSL_RDDATA_RESET 8'h00

`define XSL_LANES_PER_BANK 4

`endif

// >>> rtl/xsl_pkg.sv
// Types shared by the status and loop-back register bank
`default_nettype none

package xsl_pkg;

  typedef logic [7:0] xsl_byte_t;

  typedef logic [3:0] xsl_lanes_t;

  typedef enum {
    XSL_SEL_RESERVED,
    XSL_SEL_REV_FLAG,
    XSL_SEL_LOOP_LOW,
    XSL_SEL_LOOP_HIGH,
    XSL_SEL_NONE
  } xsl_sel_t;

endpackage : xsl_pkg

`default_nettype wire

// >>> rtl/xsl_cfg_if.sv
// Link between the register decoder and the loop-back bank
`timescale 1ns/10ps
`default_nettype none

interface xsl_cfg_if;
  logic wrLow;
  logic wrHigh;
  logic restore;
  xsl_pkg::xsl_byte_t wrData;
  xsl_pkg::xsl_byte_t loopLow;
  xsl_pkg::xsl_byte_t loopHigh;

  modport ctrl (
    output wrLow,
    output wrHigh,
    output restore,
    output wrData,
    input loopLow,
    input loopHigh
  );

  modport bank (
    input wrLow,
    input wrHigh,
    input restore,
    input wrData,
    output loopLow,
    output loopHigh
  );
endinterface : xsl_cfg_if

`default_nettype wire

// >>> rtl/xsl_loop_bank.sv
// Reverse loop-back enable registers for banks 0 to 3
`timescale 1ns/10ps
`default_nettype none

module xsl_loop_bank (
  input wire logic clk,
  input wire logic rstSyncN,
  xsl_cfg_if.bank cfg
);

  // ---------------------------------------------------------------
  // Next values
  // ---------------------------------------------------------------
  xsl_pkg::xsl_byte_t loopLow_q;
  xsl_pkg::xsl_byte_t loopLow_d;
  xsl_pkg::xsl_byte_t loopHigh_q;
  xsl_pkg::xsl_byte_t loopHigh_d;

  always_comb begin
    loopLow_d = loopLow_q;
    loopHigh_d = loopHigh_q;
    // Restore wins: it only comes from a write elsewhere, never together
    if (cfg.restore) begin
      loopLow_d = `XSL_LOOP_RESET;
      loopHigh_d = `XSL_LOOP_RESET;
    end else begin
      if (cfg.wrLow) begin
        loopLow_d = cfg.wrData;
      end
      if (cfg.wrHigh) begin
        loopHigh_d = cfg.wrData;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      loopLow_q <= `XSL_LOOP_RESET;
      loopHigh_q <= `XSL_LOOP_RESET;
    end else begin
      loopLow_q <= loopLow_d;
      loopHigh_q <= loopHigh_d;
    end
  end

  assign cfg.loopLow = loopLow_q;
  assign cfg.loopHigh = loopHigh_q;

endmodule : xsl_loop_bank

`default_nettype wire

// >>> verif/xsl_regs_sva.sv
// Checker of the status and loop-back register bank
`timescale 1ns/10ps
`default_nettype none
module xsl_regs_sva #(
  parameter logic [6:0] REVISION = 7'h01
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  input wire logic [3:0] reverseLoopBank0,
  input wire logic [3:0] reverseLoopBank1,
  input wire logic [3:0] reverseLoopBank2,
  input wire logic [3:0] reverseLoopBank3,
  input wire logic powerOnFlag
);
  // ------
  // Properties
  // ------
  logic [15:0] loops;
  assign loops = {reverseLoopBank3, reverseLoopBank2, reverseLoopBank1,
    reverseLoopBank0};
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_REV_READ:
    assert property (regRdEn && regAddr == 8'h01 |=> regRdValid
      && regRdData[6:0] == REVISION) else $error("revision read wrong");
  AST_FLAG_READ:
    assert property (regRdEn && regAddr == 8'h01 |=>
      regRdData[7] == $past(powerOnFlag)) else $error("flag read wrong");
  AST_FLAG_NO_SET:
    assert property (!$rose(powerOnFlag)) else $error("flag set by write");
  AST_RESET_LOAD:
    assert property (disable iff (1'b0) !resetn ##1 !resetn |-> powerOnFlag
      && loops == 16'h0000) else $error("reset defaults wrong");
  AST_FLAG_CLEAR:
    assert property (regWrEn && regAddr == 8'h01 |=> !powerOnFlag
      && loops == 16'h0000) else $error("flag clear wrong");
  AST_LOW_WRITE:
    assert property (regWrEn && regAddr == 8'h02 |=>
      loops[7:0] == $past(regWrData)) else $error("low banks wrong");
  AST_HIGH_WRITE:
    assert property (regWrEn && regAddr == 8'h03 |=>
      loops[15:8] == $past(regWrData)) else $error("high banks wrong");
  AST_IDLE_HOLD:
    assert property (!regWrEn || regAddr == 8'h00 || regAddr > 8'h03 |=>
      $stable(loops) && $stable(powerOnFlag)) else $error("state moved");
  // Clearing with lanes on is the case most likely to be missed
  cover property (regWrEn && regAddr == 8'h01 && loops != 16'h0000);
  cover property (regWrEn && regAddr == 8'h00);
  cover property (regRdValid && regRdData[7]);
endmodule : xsl_regs_sva
bind xsl_status_loopback_regs xsl_regs_sva #(.REVISION(REVISION)) chkU (
  .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrEn(regWrEn),
  .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
  .regRdValid(regRdValid), .reverseLoopBank0(reverseLoopBank0),
  .reverseLoopBank1(reverseLoopBank1), .reverseLoopBank2(reverseLoopBank2),
  .reverseLoopBank3(reverseLoopBank3), .powerOnFlag(powerOnFlag));
`default_nettype wire

// >>> verif/xsl_host_model.sv
// Register host that issues single writes and reads
`timescale 1ns/10ps
`default_nettype none
module xsl_host_model (
  output var logic [7:0] regAddr,
  output var logic regWrEn,
  output var logic [7:0] regWrData,
  output var logic regRdEn,
  input wire logic clk,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid
);
  // ------
  // Host tasks
  // ------
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end
  // Idle data is inverted so a stale byte cannot pass for a fresh one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    regWrData <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
    output logic ok);
    ok = 1'b0;
    d = 8'hXX;
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge clk);
      if (regRdValid === 1'b1) begin
        ok = 1'b1;
        d = regRdData;
      end
    end
  endtask : rd
endmodule : xsl_host_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench of the status and loop-back register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ------
  // Bench
  // ------
  localparam logic [6:0] REV = 7'h35; // Arbitrary revision value
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regWrEn, regRdEn, regRdValid, powerOnFlag;
  logic [3:0] lb0, lb1, lb2, lb3;
  int errCount = 0;
  int checksDone = 0;
  always #2.5 clk = ~clk;
  xsl_status_loopback_regs #(.REVISION(REV)) dut_u (.clk(clk),
    .resetn(resetn), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .reverseLoopBank0(lb0),
    .reverseLoopBank1(lb1), .reverseLoopBank2(lb2),
    .reverseLoopBank3(lb3), .powerOnFlag(powerOnFlag));
  xsl_host_model host_u (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid));
  task automatic wrapUp();
    if (errCount == 0 && checksDone > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrapUp
  task automatic chk(input string name, input logic [7:0] seen, exp);
    checksDone++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host_u.rd(a, d, ok);
    chk("read valid", {7'h00, ok}, 8'h01);
    if (!ok) begin
      wrapUp();
    end
    chk("read data", d, exp);
  endtask : rdChk
  // Sampled on the falling edge, after the write edge has settled
  task automatic outChk(input logic [15:0] lp, input logic flag);
    @(negedge clk);
    chk("low banks", {lb1, lb0}, lp[7:0]);
    chk("high banks", {lb3, lb2}, lp[15:8]);
    chk("flag", {7'h00, powerOnFlag}, {7'h00, flag});
  endtask : outChk
  task automatic doReset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : doReset
  task automatic scReset();
    outChk(16'h0000, 1'b1);
    rdChk(8'h01, {1'b1, REV});
    rdChk(8'h02, 8'h00);
    rdChk(8'h03, 8'h00);
  endtask : scReset
  task automatic scLanes();
    for (int i = 0; i < 8; i++) begin
      host_u.wr(8'h02, 8'h01 << i);
      host_u.wr(8'h03, 8'h80 >> i);
      outChk({8'h80 >> i, 8'h01 << i}, 1'b1);
    end
    host_u.wr(8'h02, 8'h5A);
    host_u.wr(8'h03, 8'hC3);
    rdChk(8'h02, 8'h5A);
    rdChk(8'h03, 8'hC3);
  endtask : scLanes
  task automatic scReserved();
    host_u.wr(8'h00, 8'hFF);
    host_u.wr(8'h04, 8'hFF);
    outChk(16'hC35A, 1'b1);
    rdChk(8'h00, 8'h00);
    rdChk(8'h04, 8'h00);
  endtask : scReserved
  task automatic scClear();
    logic [7:0] vals [3] = '{8'h00, 8'hFF, 8'h7F};
    foreach (vals[k]) begin
      doReset();
      host_u.wr(8'h02, 8'hFF);
      host_u.wr(8'h03, 8'hFF);
      host_u.wr(8'h01, vals[k]);
      outChk(16'h0000, 1'b0);
      rdChk(8'h01, {1'b0, REV});
    end
  endtask : scClear
  task automatic scPor();
    host_u.wr(8'h02, 8'h3C);
    doReset();
    outChk(16'h0000, 1'b1);
    rdChk(8'h01, {1'b1, REV});
  endtask : scPor
  initial begin
    doReset();
    scReset();
    scLanes();
    scReserved();
    scClear();
    scPor();
    wrapUp();
  end
endmodule : testbench
`default_nettype wire
